// file: bench/sbx_mem_model.sv
// Purpose: Byte stack memory
// Assumes: Synchronous to pclk
// Notes:   Idle data is the inverse of the last byte
`timescale 1ns/1ps
// ========
// Memory model
module sbx_mem_model (
    // Memory port
    input wire logic        pclk, mem_rd, mem_wr, mem_last,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0]  mem_wdata,
    output logic     [7:0]  mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    always @(posedge pclk) begin
        if (mem_wr && mem_last) mem[mem_addr] <= mem_wdata;
        if (mem_rd) last_q <= mem[mem_addr];
    end
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule : sbx_mem_model

// file: bench/sbx_props.sv
// Purpose: Port properties
// Assumes: One clock domain
// Notes:   W is unseen here, so cycle length is a lower bound
`timescale 1ns/1ps
// ========
// Checker
module sbx_props (
    // Watched ports
    input wire logic        pclk, presetn, psel, penable, pslverr,
    input wire logic        mem_rd, mem_wr, mem_last,
    input wire logic [7:0]  paddr,
    input wire logic [15:0] mem_addr
);
    wire act = mem_rd | mem_wr;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rd_wr_apart: assert property (!(mem_rd && mem_wr)) else $error("rd with wr");
    a_last_in_cyc: assert property (mem_last |-> act) else $error("stray last");
    a_cyc_min_len: assert property (mem_last |-> $past(act) && $past(act, 2))
        else $error("short cycle");
    a_addr_held: assert property (act && !mem_last |=> $stable(mem_addr))
        else $error("addr moved");
    a_rd_step_up: assert property (mem_rd && mem_last ##1 mem_rd |->
        mem_addr == $past(mem_addr) + 16'h0001) else $error("read order");
    a_wr_step: assert property (mem_wr && mem_last ##1 mem_wr |->
        mem_addr == $past(mem_addr) - 16'h0001 || mem_addr == $past(mem_addr) + 16'h0001)
        else $error("write order");
    a_swap_turn: assert property (mem_rd && mem_last ##1 mem_wr |->
        mem_addr == $past(mem_addr) - 16'h0001) else $error("swap order");
    a_err_unmapped: assert property (psel && penable && paddr >= 8'h24 |-> pslverr)
        else $error("no slverr");
endmodule : sbx_props

// file: bench/tb_top.sv
// Purpose: Bench for the stack and branch block
// Assumes: Model memory answers in every state
// Notes:   Memory states are counted
`timescale 1ns/1ps
// ========
// Bench
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready, pslverr, e, t, mem_rd, mem_wr, mem_last;
    logic [7:0]  paddr = 8'h00, mem_wdata, mem_rdata, f;
    logic [15:0] mem_addr;
    logic [31:0] pwdata = 32'h0, prdata, r, fb;
    int          err_total = 0, check_count = 0, act = 0, a0;
    sbx_stack_branch_exec i_sbx_stack_branch_exec (.*);
    sbx_mem_model         i_sbx_mem_model (.*);
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (mem_rd | mem_wr) act <= act + 1;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string s, input logic [31:0] g, x);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
        int n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk) n++; while (pready !== 1'b1 && n < 50);
        r = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin err_total++; report_and_stop(); end
        @(posedge pclk);
    endtask : apb
    task automatic ex(input logic [7:0] op);
        int i = 0;
        a0 = act;
        apb(1'b1, 8'h00, {24'h0, op});
        do begin apb(1'b0, 8'h04); i++; end while (r[0] !== 1'b0 && i < 40);
        if (i >= 40) begin err_total++; report_and_stop(); end
    endtask : ex
    function automatic logic [7:0] mb(input logic [15:0] a);
        return i_sbx_mem_model.mem[a];
    endfunction : mb
    task automatic t_stack;
        apb(1'b1, 8'h08, 32'h1); apb(1'b1, 8'h10, 32'h0); apb(1'b1, 8'h18, 32'h1234);
        ex(8'hC5);
        chk("push", {mb(16'hFFFF), mb(16'hFFFE)}, 32'h1234);
        chk("push_len", act - a0, 32'd10);
        apb(1'b0, 8'h10);
        chk("sp_wrap", r, 32'hFFFE);
        i_sbx_mem_model.mem[16'hFFFE] = 8'hD5;
        i_sbx_mem_model.mem[16'hFFFF] = 8'hA5;
        ex(8'hF1);
        apb(1'b0, 8'h20);
        chk("pop_sw", r, 32'hA5D7);
        chk("pop_len", act - a0, 32'd10);
        ex(8'hF5);
        chk("sw_byte", mb(16'hFFFE), 32'hD7);
        ex(8'hD1);
        apb(1'b0, 8'h1C);
        chk("pop_de", r, 32'hA5D7);
        $display("stack test done");
    endtask : t_stack
    task automatic t_ret;
        apb(1'b1, 8'h08, 32'h0);
        for (int k = 0; k < 16; k++) begin
            fb = {8'h80, 8'h04, 8'h01, 8'h40} >> {k[2:1], 3'b000};
            f = k[3] ? fb[7:0] | 8'h02 : fb[7:0] ^ 8'hD7;
            t = k[0] ^ ~k[3];
            apb(1'b1, 8'h20, {24'h0, f}); apb(1'b1, 8'h10, 32'h4000); apb(1'b1, 8'h0C, 32'h100);
            i_sbx_mem_model.mem[16'h4000] = k[7:0];
            i_sbx_mem_model.mem[16'h4001] = 8'h77;
            ex(8'hC0 | {2'b00, k[2:0], 3'b000});
            apb(1'b0, 8'h0C);
            chk("ret_pc", r, t ? 32'h7700 + k : 32'h100);
            chk("ret_len", act - a0, t ? 32'd6 : 32'd0);
            apb(1'b0, 8'h20);
            chk("ret_flags", r, {24'h0, f});
            apb(1'b0, 8'h04);
            chk("ret_taken", r[1], t);
        end
        $display("return test done");
    endtask : t_ret
    task automatic t_misc;
        apb(1'b1, 8'h08, 32'h2); apb(1'b1, 8'h10, 32'h8001); apb(1'b1, 8'h0C, 32'hABCD);
        ex(8'hEF);
        apb(1'b0, 8'h0C);
        chk("rst_pc", r, 32'h28);
        chk("rst_push", {mb(16'h8000), mb(16'h7FFF)}, 32'hABCD);
        apb(1'b1, 8'h14, 32'h5566);
        ex(8'hE3);
        chk("swap_len", act - a0, 32'd28);
        chk("swap_mem", {mb(16'h8000), mb(16'h7FFF)}, 32'h5566);
        apb(1'b0, 8'h10);
        chk("swap_sp", r, 32'h7FFF);
        ex(8'hE9); ex(8'hF9);
        apb(1'b0, 8'h0C);
        chk("jump_pc", r, 32'hABCD);
        apb(1'b0, 8'h10);
        chk("sp_hl", r, 32'hABCD);
        ex(8'h00);
        apb(1'b0, 8'h04);
        chk("illegal", r[2], 1'b1);
        apb(1'b0, 8'h40);
        chk("unmapped", {e, r[30:0]}, 32'h80000000);
        $display("misc test done");
    endtask : t_misc
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_stack(); t_ret(); t_misc();
        report_and_stop();
    end
endmodule : tb_top
bind sbx_stack_branch_exec sbx_props i_sbx_props (.*);

// file: hw/sbx_cond_eval.sv
// Purpose: Branch condition check
// Assumes: Flags from same-clock registers
// Notes:   Purely combinational

`timescale 1ns/1ps

// ==========================================================================
// Condition check
module sbx_cond_eval (
    // Condition field
    input  wire logic [2:0] condition_field,
    // Flags
    input  wire logic       zero_flag,
    input  wire logic       carry_flag,
    input  wire logic       parity_flag,
    input  wire logic       sign_flag,
    // Result
    output logic            cond_true
);
    logic sel;

    always_comb begin
        case (condition_field[2:1]) // RL14
            2'b00:   sel = zero_flag;
            2'b01:   sel = carry_flag;
            2'b10:   sel = parity_flag;
            2'b11:   sel = sign_flag;
            default: sel = 1'b0;
        endcase
        // Low bit picks the set sense, clear sense otherwise
        cond_true = condition_field[0] ? sel : !sel; // RL14
    end

endmodule : sbx_cond_eval

// file: hw/sbx_cyc_if.sv
// Purpose: Sequencer to timer carrier
// Assumes: Single pclk domain
// Notes:   start reloads the timer even while it runs

`timescale 1ns/1ps

// ==========================================================================
// Interface
interface sbx_cyc_if;
    logic       start;
    logic [5:0] base;
    logic [3:0] wcnt;
    logic       done;

    modport timer (input start, input base, input wcnt, output done);
    modport ctrl  (output start, output base, output wcnt, input done);
endinterface : sbx_cyc_if

// file: hw/sbx_cycle_timer.sv
// Purpose: Counts the states of one machine cycle
// Assumes: Wait count steady per cycle
// Notes:   done marks the last state

`timescale 1ns/1ps

// ==========================================================================
// State timer
module sbx_cycle_timer (
    // Clock and reset
    input wire logic  pclk,
    input wire logic  presetn,
    // Sequencer side
    sbx_cyc_if.timer  cyc
);
    logic [5:0] cnt_q, cnt_d;
    logic [5:0] len_q, len_d;
    logic       run_q, run_d;

    always_comb begin
        cnt_d = cnt_q;
        len_d = len_q;
        run_d = run_q;
        if (cyc.start) begin
            cnt_d = '0;
            len_d = cyc.base + {1'b0, cyc.wcnt, 1'b0}; // RL16
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == len_q - 6'h01) begin
                run_d = 1'b0;
            end else begin
                cnt_d = cnt_q + 6'h01;
            end
        end
    end

    assign cyc.done = run_q && (cnt_q == len_q - 6'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            len_q <= '0;
            run_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            len_q <= len_d;
            run_q <= run_d;
        end
    end

endmodule : sbx_cycle_timer

// file: hw/sbx_pkg.sv
// Purpose: Constants and types of the stack and branch block
// Assumes: 8-bit data, 16-bit memory addresses, APB register window
// Notes:   One state is one pclk cycle

// ==========================================================================
// Package
package sbx_pkg;

    // ======================================================================
    // Register map
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_STATUS  = 8'h04;
    localparam logic [7:0] OFF_WAIT    = 8'h08;
    localparam logic [7:0] OFF_PC      = 8'h0C;
    localparam logic [7:0] OFF_SP      = 8'h10;
    localparam logic [7:0] OFF_HL      = 8'h14;
    localparam logic [7:0] OFF_BC      = 8'h18;
    localparam logic [7:0] OFF_DE      = 8'h1C;
    localparam logic [7:0] OFF_AF      = 8'h20;

    // Status bits
    localparam int STAT_BUSY    = 0;
    localparam int STAT_TAKEN   = 1;
    localparam int STAT_ILLEGAL = 2;

    // ======================================================================
    // Opcodes and masks
    localparam logic [7:0] MASK_CCC = 8'hC7;
    localparam logic [7:0] MASK_RP  = 8'hCF;
    localparam logic [7:0] OP_RETC  = 8'hC0;
    localparam logic [7:0] OP_RST   = 8'hC7;
    localparam logic [7:0] OP_PUSH  = 8'hC5;
    localparam logic [7:0] OP_POP   = 8'hC1;
    localparam logic [7:0] OP_JHL   = 8'hE9;
    localparam logic [7:0] OP_SWAP_STACK_TOP_HL  = 8'hE3;
    localparam logic [7:0] OP_LOAD_SP_FROM_HL  = 8'hF9;
    localparam logic [1:0] RP_AF    = 2'h3;

    // ======================================================================
    // Timing in states
    localparam logic [5:0] FETCH_LONG  = 6'h06;
    localparam logic [5:0] FETCH_SHORT = 6'h04;
    localparam logic [5:0] MEM_BASE    = 6'h03;
    localparam int         WAIT_W      = 4;

    // ======================================================================
    // Stack offsets, modulo 65536
    localparam logic [15:0] SP_OFF_0  = 16'h0000;
    localparam logic [15:0] SP_OFF_P1 = 16'h0001;
    localparam logic [15:0] SP_OFF_M1 = 16'hFFFF;
    localparam logic [15:0] SP_OFF_M2 = 16'hFFFE;
    localparam logic [15:0] SP_STEP   = 16'h0002;

    // Status word byte: S Z 0 AC 0 P 1 CY
    localparam int         PSW_S     = 7;
    localparam int         PSW_Z     = 6;
    localparam int         PSW_AC    = 4;
    localparam int         PSW_P     = 2;
    localparam int         PSW_CY    = 0;
    localparam logic [7:0] PSW_FIXED = 8'h02;

    typedef enum logic [1:0] {
        SBX_IDLE  = 2'b00,
        SBX_FETCH = 2'b01,
        SBX_MEM   = 2'b10
    } sbx_state_t;

    typedef enum logic [2:0] {
        K_RETC = 3'b000,
        K_RST  = 3'b001,
        K_JHL  = 3'b010,
        K_PUSH = 3'b011,
        K_POP  = 3'b100,
        K_SWAP_STACK_TOP_HL = 3'b101,
        K_LOAD_SP_FROM_HL = 3'b110,
        K_BAD  = 3'b111
    } sbx_kind_t;

endpackage : sbx_pkg

// file: hw/sbx_stack_branch_exec.sv
// Purpose: Stack and branch instruction execution
// Assumes: Memory answers on pclk; read data valid when mem_last is high
// Notes:   An APB write issues the opcode
//
// Contract
// RL1: Taken return loads pc low from mem[SP], high from mem[SP+1], SP += 2.
// RL2: Return takes 1 cycle, 6+2W states; taken 3 cycles, 12+6W.
// RL3: Only pop of the status word alters flags.
// RL4: Restart pushes pc (high SP-1, low SP-2), SP -= 2, pc = 8 * number.
// RL5: Jump via HL sets pc = {H, L} in 6+2W states.
// RL6: Push puts high reg at SP-1, low reg at SP-2, SP -= 2.
// RL7: Software never names SP as push or pop operand.
// RL8: Status push puts A at SP-1, flag byte S Z 0 AC 0 P 1 CY at SP-2.
// RL9: Pop loads low reg from mem[SP], high from mem[SP+1], SP += 2.
// RL10: Pop takes 3 cycles, 10+6W states, addressed through SP.
// RL11: Status pop loads five flags from mem[SP], A from mem[SP+1].
// RL12: Swap trades L with mem[SP], H with mem[SP+1], SP kept, 16+10W states.
// RL13: Load SP sets SP = HL in 6+2W states.
// RL14: Condition codes 000 to 111 test NZ, Z, NC, C, PO, PE, P, M.
// RL15: Stack addresses wrap modulo 65536.
// RL16: Each wait adds two states per machine cycle.
//
// The APB slave port and the placing of the registers were decided locally.

`timescale 1ns/1ps

// ==========================================================================
// Top
module sbx_stack_branch_exec (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [sbx_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Stack memory
    output logic      [15:0]               mem_addr,
    output logic      [7:0]                mem_wdata,
    input  wire logic [7:0]                mem_rdata,
    output logic                           mem_rd,
    output logic                           mem_wr,
    output logic                           mem_last
);

    // ======================================================================
    // State
    sbx_pkg::sbx_state_t state_q, state_d;
    sbx_pkg::sbx_kind_t  kind_q,  kind_d;
    logic [7:0]  op_q, op_d;
    logic        go_q, go_d;
    logic [1:0]  idx_q, idx_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0]  a_q, a_d, b_q, b_d, c_q, c_d, d_q, d_d, e_q, e_d, h_q, h_d, l_q, l_d;
    logic        fs_q, fs_d, fz_q, fz_d, fac_q, fac_d, fp_q, fp_d, fcy_q, fcy_d;
    logic [7:0]  t0_q, t0_d, t1_q, t1_d;
    logic [3:0]  wait_q, wait_d;
    logic        taken_q, taken_d, ill_q, ill_d;
    logic [31:0] prdata_q, prdata_d;
    logic [15:0] maddr_q, maddr_d;
    logic [7:0]  mwdata_q, mwdata_d;
    logic        mrd_q, mrd_d, mwr_q, mwr_d;

    sbx_cyc_if cyc ();
    logic       cond_ok;
    logic [7:0] psw_byte;
    logic [1:0] ncyc;
    logic [1:0] nidx;
    logic [1:0] rp;
    logic       wr_acc;
    logic       rd_setup;
    logic       mapped;
    logic [15:0] plan_off;
    logic        plan_wr;
    logic [7:0]  plan_wdata;
    logic [31:0] rd_val;

    sbx_cycle_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .cyc     (cyc)
    );

    sbx_cond_eval u_cond (
        .condition_field (op_q[5:3]),
        .zero_flag       (fz_q),
        .carry_flag      (fcy_q),
        .parity_flag     (fp_q),
        .sign_flag       (fs_q),
        .cond_true       (cond_ok)
    );

    // ======================================================================
    // Decode
    function automatic sbx_pkg::sbx_kind_t sbx_decode(input logic [7:0] op);
        sbx_pkg::sbx_kind_t k;
        k = sbx_pkg::K_BAD;
        if ((op & sbx_pkg::MASK_CCC) == sbx_pkg::OP_RETC) k = sbx_pkg::K_RETC;
        if ((op & sbx_pkg::MASK_CCC) == sbx_pkg::OP_RST)  k = sbx_pkg::K_RST;
        if ((op & sbx_pkg::MASK_RP) == sbx_pkg::OP_PUSH)  k = sbx_pkg::K_PUSH;
        if ((op & sbx_pkg::MASK_RP) == sbx_pkg::OP_POP)   k = sbx_pkg::K_POP;
        if (op == sbx_pkg::OP_JHL)  k = sbx_pkg::K_JHL;
        if (op == sbx_pkg::OP_SWAP_STACK_TOP_HL) k = sbx_pkg::K_SWAP_STACK_TOP_HL;
        if (op == sbx_pkg::OP_LOAD_SP_FROM_HL) k = sbx_pkg::K_LOAD_SP_FROM_HL;
        return k;
    endfunction : sbx_decode

    assign rp       = op_q[5:4];
    assign psw_byte = sbx_pkg::PSW_FIXED | {fs_q, fz_q, 1'b0, fac_q, 1'b0, fp_q, 1'b0, fcy_q}; // RL8
    assign nidx     = (state_q == sbx_pkg::SBX_FETCH) ? 2'h0 : idx_q + 2'h1;

    // ======================================================================
    // Plan of the next memory cycle
    always_comb begin
        ncyc       = 2'h2;
        plan_off   = (nidx[0]) ? sbx_pkg::SP_OFF_P1 : sbx_pkg::SP_OFF_0;
        plan_wr    = 1'b0;
        plan_wdata = 8'h00;
        case (kind_q)
            sbx_pkg::K_RETC: ncyc = cond_ok ? 2'h2 : 2'h0; // RL1
            sbx_pkg::K_PUSH, sbx_pkg::K_RST: begin
                plan_off = nidx[0] ? sbx_pkg::SP_OFF_M2 : sbx_pkg::SP_OFF_M1; // RL6
                plan_wr  = 1'b1;
                if (kind_q == sbx_pkg::K_RST) begin
                    plan_wdata = nidx[0] ? pc_q[7:0] : pc_q[15:8]; // RL4
                end else begin
                    case (rp) // RL6
                        2'h0:    plan_wdata = nidx[0] ? c_q : b_q;
                        2'h1:    plan_wdata = nidx[0] ? e_q : d_q;
                        2'h2:    plan_wdata = nidx[0] ? l_q : h_q;
                        default: plan_wdata = nidx[0] ? psw_byte : a_q; // RL8
                    endcase
                end
            end
            sbx_pkg::K_SWAP_STACK_TOP_HL: begin
                ncyc       = 2'h3; // RL12
                plan_wr    = nidx[1];
                plan_wdata = nidx[0] ? h_q : l_q;
            end
            sbx_pkg::K_POP:  ncyc = 2'h2; // RL10
            default:         ncyc = 2'h0;
        endcase
    end

    // ======================================================================
    // APB decode
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            sbx_pkg::OFF_CTRL:   rd_val = {24'h00_0000, op_q};
            sbx_pkg::OFF_STATUS: rd_val = {29'h0000_0000, ill_q, taken_q,
                                           (state_q != sbx_pkg::SBX_IDLE) || go_q};
            sbx_pkg::OFF_WAIT:   rd_val = {28'h000_0000, wait_q};
            sbx_pkg::OFF_PC:     rd_val = {16'h0000, pc_q};
            sbx_pkg::OFF_SP:     rd_val = {16'h0000, sp_q};
            sbx_pkg::OFF_HL:     rd_val = {16'h0000, h_q, l_q};
            sbx_pkg::OFF_BC:     rd_val = {16'h0000, b_q, c_q};
            sbx_pkg::OFF_DE:     rd_val = {16'h0000, d_q, e_q};
            sbx_pkg::OFF_AF:     rd_val = {16'h0000, a_q, psw_byte};
            default:             mapped = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    // ======================================================================
    // Next state
    always_comb begin
        state_d = state_q;  kind_d = kind_q;  op_d = op_q;  go_d = go_q;  idx_d = idx_q;
        pc_d = pc_q;  sp_d = sp_q;  a_d = a_q;  b_d = b_q;  c_d = c_q;  d_d = d_q;
        e_d = e_q;  h_d = h_q;  l_d = l_q;  t0_d = t0_q;  t1_d = t1_q;
        fs_d = fs_q;  fz_d = fz_q;  fac_d = fac_q;  fp_d = fp_q;  fcy_d = fcy_q;
        wait_d = wait_q;  taken_d = taken_q;  ill_d = ill_q;
        prdata_d = rd_setup ? rd_val : prdata_q;
        maddr_d = maddr_q;  mwdata_d = mwdata_q;  mrd_d = mrd_q;  mwr_d = mwr_q;
        cyc.start = 1'b0;
        cyc.base  = sbx_pkg::MEM_BASE;
        cyc.wcnt  = wait_q;

        // Register writes ignored while busy; the status clear below is not
        if (wr_acc && state_q == sbx_pkg::SBX_IDLE && !go_q) begin
            case (paddr)
                sbx_pkg::OFF_CTRL: begin
                    op_d = pwdata[7:0];
                    go_d = 1'b1;
                end
                sbx_pkg::OFF_WAIT: wait_d = pwdata[sbx_pkg::WAIT_W-1:0];
                sbx_pkg::OFF_PC:   pc_d = pwdata[15:0];
                sbx_pkg::OFF_SP:   sp_d = pwdata[15:0];
                sbx_pkg::OFF_HL:   {h_d, l_d} = pwdata[15:0];
                sbx_pkg::OFF_BC:   {b_d, c_d} = pwdata[15:0];
                sbx_pkg::OFF_DE:   {d_d, e_d} = pwdata[15:0];
                sbx_pkg::OFF_AF: begin
                    a_d   = pwdata[15:8];
                    fs_d  = pwdata[sbx_pkg::PSW_S];
                    fz_d  = pwdata[sbx_pkg::PSW_Z];
                    fac_d = pwdata[sbx_pkg::PSW_AC];
                    fp_d  = pwdata[sbx_pkg::PSW_P];
                    fcy_d = pwdata[sbx_pkg::PSW_CY];
                end
                default: ;
            endcase
        end
        // Write one to clear; a same-cycle fault wins
        if (wr_acc && paddr == sbx_pkg::OFF_STATUS && pwdata[sbx_pkg::STAT_ILLEGAL]) begin
            ill_d = 1'b0;
        end

        case (state_q)
            sbx_pkg::SBX_IDLE: begin
                if (go_q) begin
                    go_d    = 1'b0;
                    kind_d  = sbx_decode(op_q);
                    taken_d = 1'b0;
                    if (sbx_decode(op_q) == sbx_pkg::K_BAD) begin
                        ill_d = 1'b1;
                    end else begin
                        cyc.start = 1'b1;
                        cyc.base  = (sbx_decode(op_q) == sbx_pkg::K_POP ||
                                     sbx_decode(op_q) == sbx_pkg::K_SWAP_STACK_TOP_HL)
                                    ? sbx_pkg::FETCH_SHORT : sbx_pkg::FETCH_LONG; // RL2
                        state_d   = sbx_pkg::SBX_FETCH;
                    end
                end
            end
            sbx_pkg::SBX_FETCH: begin
                if (cyc.done) begin
                    if (kind_q == sbx_pkg::K_JHL)  pc_d = {h_q, l_q}; // RL5
                    if (kind_q == sbx_pkg::K_LOAD_SP_FROM_HL) sp_d = {h_q, l_q}; // RL13
                    if (kind_q == sbx_pkg::K_RETC) taken_d = cond_ok;
                    if (ncyc == 2'h0) begin
                        // Untaken return falls through
                        state_d = sbx_pkg::SBX_IDLE; // RL2
                    end else begin
                        cyc.start = 1'b1;
                        idx_d     = nidx;
                        maddr_d   = sp_q + plan_off; // RL15
                        mwdata_d  = plan_wdata;
                        mwr_d     = plan_wr;
                        mrd_d     = !plan_wr;
                        state_d   = sbx_pkg::SBX_MEM;
                    end
                end
            end
            sbx_pkg::SBX_MEM: begin
                if (cyc.done) begin
                    if (mrd_q) begin
                        case (kind_q)
                            sbx_pkg::K_RETC: begin // RL1
                                if (idx_q[0]) pc_d[15:8] = mem_rdata;
                                else          pc_d[7:0]  = mem_rdata;
                            end
                            sbx_pkg::K_POP: begin // RL9
                                case (rp)
                                    2'h0: if (idx_q[0]) b_d = mem_rdata; else c_d = mem_rdata;
                                    2'h1: if (idx_q[0]) d_d = mem_rdata; else e_d = mem_rdata;
                                    2'h2: if (idx_q[0]) h_d = mem_rdata; else l_d = mem_rdata;
                                    default: begin // RL11
                                        if (idx_q[0]) begin
                                            a_d = mem_rdata;
                                        end else begin
                                            fs_d  = mem_rdata[sbx_pkg::PSW_S];
                                            fz_d  = mem_rdata[sbx_pkg::PSW_Z];
                                            fac_d = mem_rdata[sbx_pkg::PSW_AC];
                                            fp_d  = mem_rdata[sbx_pkg::PSW_P];
                                            fcy_d = mem_rdata[sbx_pkg::PSW_CY];
                                        end
                                    end
                                endcase
                            end
                            default: begin
                                if (idx_q[0]) t1_d = mem_rdata;
                                else          t0_d = mem_rdata;
                            end
                        endcase
                    end
                    if ((idx_q == ncyc - 2'h1 && ncyc != 2'h3) || idx_q == 2'h3) begin // RL12
                        mrd_d   = 1'b0;
                        mwr_d   = 1'b0;
                        state_d = sbx_pkg::SBX_IDLE;
                        case (kind_q)
                            sbx_pkg::K_RETC, sbx_pkg::K_POP: sp_d = sp_q + sbx_pkg::SP_STEP; // RL9
                            sbx_pkg::K_PUSH: sp_d = sp_q - sbx_pkg::SP_STEP; // RL6
                            sbx_pkg::K_RST: begin
                                sp_d = sp_q - sbx_pkg::SP_STEP; // RL4
                                pc_d = {10'h000, op_q[5:3], 3'h0}; // RL4
                            end
                            sbx_pkg::K_SWAP_STACK_TOP_HL: begin // RL12
                                l_d = t0_q;
                                h_d = t1_q;
                            end
                            default: ;
                        endcase
                    end else begin
                        cyc.start = 1'b1;
                        idx_d     = nidx;
                        maddr_d   = sp_q + plan_off; // RL15
                        mwdata_d  = plan_wdata;
                        mwr_d     = plan_wr;
                        mrd_d     = !plan_wr;
                    end
                end
            end
            default: state_d = sbx_pkg::SBX_IDLE;
        endcase
    end

    // Flags are touched only by the status-word paths above
    // RL3

    assign mem_addr  = maddr_q;
    assign mem_wdata = mwdata_q;
    assign mem_rd    = mrd_q;
    assign mem_wr    = mwr_q;
    assign mem_last  = (state_q == sbx_pkg::SBX_MEM) && cyc.done;

    // ======================================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= sbx_pkg::SBX_IDLE;  kind_q <= sbx_pkg::K_BAD;
            op_q <= 8'h00;  go_q <= 1'b0;  idx_q <= 2'h0;
            pc_q <= 16'h0000;  sp_q <= 16'h0000;
            a_q <= 8'h00;  b_q <= 8'h00;  c_q <= 8'h00;  d_q <= 8'h00;
            e_q <= 8'h00;  h_q <= 8'h00;  l_q <= 8'h00;  t0_q <= 8'h00;  t1_q <= 8'h00;
            fs_q <= 1'b0;  fz_q <= 1'b0;  fac_q <= 1'b0;  fp_q <= 1'b0;  fcy_q <= 1'b0;
            wait_q <= 4'h0;  taken_q <= 1'b0;  ill_q <= 1'b0;  prdata_q <= 32'h0000_0000;
            maddr_q <= 16'h0000;  mwdata_q <= 8'h00;  mrd_q <= 1'b0;  mwr_q <= 1'b0;
        end else begin
            state_q <= state_d;  kind_q <= kind_d;  op_q <= op_d;  go_q <= go_d;
            idx_q <= idx_d;  pc_q <= pc_d;  sp_q <= sp_d;
            a_q <= a_d;  b_q <= b_d;  c_q <= c_d;  d_q <= d_d;
            e_q <= e_d;  h_q <= h_d;  l_q <= l_d;  t0_q <= t0_d;  t1_q <= t1_d;
            fs_q <= fs_d;  fz_q <= fz_d;  fac_q <= fac_d;  fp_q <= fp_d;  fcy_q <= fcy_d;
            wait_q <= wait_d;  taken_q <= taken_d;  ill_q <= ill_d;  prdata_q <= prdata_d;
            maddr_q <= maddr_d;  mwdata_q <= mwdata_d;  mrd_q <= mrd_d;  mwr_q <= mwr_d;
        end
    end

endmodule : sbx_stack_branch_exec
